// file: rtl/video_attribute_serializer.sv
// Chosen here: the address map and register access over APB.
`timescale 1ns/1ps

`include "video_attribute_serializer_defines.svh"

module video_attribute_serializer
	import video_attribute_serializer_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [9:0]  parallel_dot_data_i,
	input  wire logic        reverse_attr_i,
	input  wire logic        highlight_attr_i,
	input  wire logic        blank_attr_i,
	input  wire logic        blink_attr_i,
	input  wire logic        underline_attr_i,
	input  wire logic        strike_attr_i,
	input  wire logic        attr_load_flag_i,
	input  wire logic        cursor_i,
	input  wire logic        half_dot_shift_i,
	input  wire logic        blanking_i,
	input  wire logic        composite_blanking_i,
	input  wire logic        background_select_i,
	input  wire logic        blink_rate_i,
	input  wire logic        underline_line_in_i,
	input  wire logic        strike_line_in_i,
	input  wire logic        last_scan_line_in_i,
	output logic             character_clock_o,
	output logic             logic_video_high_o,
	output logic             logic_video_low_o,
	output level_t           video_level_o,
	output logic             half_dot_o
);

	// ***************************************************************
	// register bus
	// ***************************************************************
	logic [`CTRL_WIDTH-1:0] ctrl_reg;
	logic                   acc;
	logic                   hit_ctrl;
	logic                   hit_stat;
	logic [3:0]             dot_cnt_reg;
	logic                   character_clock_reg;
	attr_t                  cur_reg;

	assign acc      = psel & penable;
	assign hit_ctrl = (paddr == `CTRL_OFFSET);
	assign hit_stat = (paddr == `STATUS_OFFSET);
	assign pready   = 1'b1;
	assign pslverr  = acc & ~hit_ctrl & ~hit_stat;

	// control register write
	always_ff @(posedge clk_i) begin
		if (rst_i)
			ctrl_reg <= `CTRL_WIDTH'(`CTRL_RESET);
		else if (acc && pwrite && hit_ctrl)
			ctrl_reg <= pwdata[`CTRL_WIDTH-1:0];
	end

	// read mux, unmapped reads as zero
	always_comb begin
		prdata = 32'h0000_0000;
		if (hit_ctrl)
			prdata[`CTRL_WIDTH-1:0] = ctrl_reg;
		else if (hit_stat) begin
			prdata[`STAT_CNT_MSB:`STAT_CNT_LSB]   = dot_cnt_reg;
			prdata[`STAT_CHARACTER_CLOCK_BIT]                = character_clock_reg;
			prdata[`STAT_ATTR_MSB:`STAT_ATTR_LSB] = cur_reg;
		end
	end

	// ***************************************************************
	// character clock counter
	// ***************************************************************
	logic [2:0] sel_reg;
	logic [2:0] sel_next;
	logic [3:0] dots;
	logic [3:0] hi_cnt;
	logic [3:0] dot_cnt_next;
	logic       boundary;
	logic       character_clock_fall;

	assign sel_next  = ctrl_reg[`CTRL_SEL_MSB:`CTRL_SEL_LSB];
	assign dots      = (sel_reg < 3'h2) ? `DOTS_MIN : {1'b0, sel_reg} + `DOTS_OFFSET;
	assign hi_cnt    = 4'((dots + 4'h1) >> 1);
	assign boundary  = (dot_cnt_reg == dots - 4'h1);
	assign character_clock_fall = (dot_cnt_reg == hi_cnt - 4'h1);
	assign dot_cnt_next = boundary ? 4'h0 : dot_cnt_reg + 4'h1;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dot_cnt_reg <= `DOT_CNT_RESET;
			sel_reg     <= 3'h0;
			character_clock_reg    <= 1'b0;
		end else begin
			dot_cnt_reg <= dot_cnt_next;
			if (boundary)
				sel_reg <= sel_next;
			character_clock_reg <= boundary ? 1'b1 : (dot_cnt_next < hi_cnt);
		end
	end

	assign character_clock_o = character_clock_reg;

	// ***************************************************************
	// video shift register
	// ***************************************************************
	logic [11:0] shift_reg;
	logic [11:0] frame;

	always_comb begin
		frame = {2'b00, parallel_dot_data_i};
		if (sel_next == `SEL_PAD_BOTH || sel_next == `SEL_PAD_FIRST)
			frame = {1'b0, parallel_dot_data_i, 1'b0};
	end

	// load on boundary, shift out lsb first
	always_ff @(posedge clk_i) begin
		if (rst_i)
			shift_reg <= 12'h000;
		else if (boundary)
			shift_reg <= frame;
		else
			shift_reg <= {1'b0, shift_reg[11:1]};
	end

	// ***************************************************************
	// attribute pipeline
	// ***************************************************************
	stage_t pipe1_reg;
	stage_t pipe2_reg;
	stage_t sample;

	assign sample = '{attr: '{reverse: reverse_attr_i, highlight: highlight_attr_i,
			blank: blank_attr_i, blink: blink_attr_i, uline: underline_attr_i,
			strike: strike_attr_i},
		load_flag: attr_load_flag_i, cursor: cursor_i, half_dot: half_dot_shift_i,
		field_mode: ctrl_reg[`CTRL_FIELD_BIT], show_ctl: ctrl_reg[`CTRL_SHOWCTL_BIT]};

	// sample on clock fall, two stages
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pipe1_reg <= '0;
			pipe2_reg <= '0;
		end else if (character_clock_fall) begin
			pipe1_reg <= sample;
			pipe2_reg <= pipe1_reg;
		end
	end

	// ***************************************************************
	// line timing latches
	// ***************************************************************
	logic blank_q_reg;
	logic blank_fall;
	logic blank_rise;
	logic blink_rate_reg;
	logic uline_line_reg;
	logic strike_line_reg;
	logic last_line_reg;

	assign blank_fall = blank_q_reg & ~blanking_i;
	assign blank_rise = ~blank_q_reg & blanking_i;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			blank_q_reg     <= 1'b0;
			blink_rate_reg  <= 1'b0;
			uline_line_reg  <= 1'b0;
			strike_line_reg <= 1'b0;
			last_line_reg   <= 1'b0;
		end else begin
			blank_q_reg <= blanking_i;
			if (blank_fall) begin
				blink_rate_reg  <= blink_rate_i;
				uline_line_reg  <= underline_line_in_i;
				strike_line_reg <= strike_line_in_i;
				last_line_reg   <= last_scan_line_in_i;
			end
		end
	end

	// ***************************************************************
	// attribute latches
	// ***************************************************************
	attr_t row_reg;
	attr_t row_next;
	logic  field_reg;
	logic  ctl_char_reg;
	logic  cursor_reg;
	logic  half_reg;

	// row end in field mode hands current set on
	assign row_next = last_line_reg ? cur_reg : row_reg;

	// apply at boundary, double buffer per row
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cur_reg      <= '0;
			row_reg      <= '0;
			field_reg    <= 1'b0;
			ctl_char_reg <= 1'b0;
			cursor_reg   <= 1'b0;
			half_reg     <= 1'b0;
		end else if (boundary) begin
			field_reg  <= pipe2_reg.field_mode;
			cursor_reg <= pipe2_reg.cursor;
			half_reg   <= pipe2_reg.half_dot;
			ctl_char_reg <= pipe2_reg.load_flag & pipe2_reg.field_mode & ~pipe2_reg.show_ctl;
			if (pipe2_reg.load_flag)
				cur_reg <= pipe2_reg.attr;
			else if (!pipe2_reg.field_mode)
				cur_reg <= '0;
		end else if (blank_rise && field_reg) begin
			cur_reg <= row_next;
			row_reg <= row_next;
		end
	end

	// ***************************************************************
	// video logic
	// ***************************************************************
	logic   dot;
	logic   uline_v;
	logic   strike_v;
	logic   nondisp;
	logic   inv;
	logic   surround;
	logic   white;
	logic   gray;
	logic   vid_hi_next;
	logic   vid_lo_next;
	level_t level_next;

	assign dot      = shift_reg[0] & ~ctl_char_reg;
	assign uline_v  = cur_reg.uline & uline_line_reg;
	assign strike_v = cur_reg.strike & strike_line_reg;
	assign nondisp  = cur_reg.blank | (cur_reg.blink & blink_rate_reg);
	assign inv      = cur_reg.reverse ^ cursor_reg ^ background_select_i;
	assign surround = nondisp | ~(dot | uline_v | strike_v);

	always_comb begin
		gray  = 1'b0;
		white = ~inv;
		if (surround)
			white = inv;
		else if (!strike_v && !cur_reg.highlight)
			gray = 1'b1;
	end

	always_comb begin
		if (composite_blanking_i) begin
			vid_hi_next = 1'b0;
			vid_lo_next = 1'b0;
			level_next  = LEVEL_BLACK;
		end else if (blanking_i) begin
			vid_hi_next = background_select_i;
			vid_lo_next = background_select_i;
			level_next  = background_select_i ? LEVEL_BLACK : LEVEL_WHITE;
		end else if (gray) begin
			vid_hi_next = inv;
			vid_lo_next = ~inv;
			level_next  = LEVEL_GRAY;
		end else begin
			vid_hi_next = white;
			vid_lo_next = white;
			level_next  = white ? LEVEL_BLACK : LEVEL_WHITE;
		end
	end

	// half-dot flag travels with the dot
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			logic_video_high_o <= 1'b0;
			logic_video_low_o  <= 1'b0;
			video_level_o      <= LEVEL_BLACK;
			half_dot_o         <= 1'b0;
		end else begin
			logic_video_high_o <= vid_hi_next;
			logic_video_low_o  <= vid_lo_next;
			video_level_o      <= level_next;
			half_dot_o         <= half_reg;
		end
	end

	// ***************************************************************
	// assertions
	// ***************************************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	property p_len12;
		(dot_cnt_reg == 4'h0 && sel_reg == 3'h7) |-> ##11 boundary;
	endproperty
	a_len12: assert property (p_len12) else $error("twelve-dot character wrong length");

	property p_duty7;
		(dot_cnt_reg == 4'h0 && sel_reg == 3'h2) |-> character_clock_reg [*4] ##1 !character_clock_reg [*3];
	endproperty
	a_duty7: assert property (p_duty7) else $error("seven-dot duty wrong");

	property p_lsb_first;
		logic [9:0] d;
		(boundary && sel_next == 3'h3, d = parallel_dot_data_i)
			|=> (shift_reg[0] == d[0]) ##1 (shift_reg[0] == d[1]);
	endproperty
	a_lsb_first: assert property (p_lsb_first) else $error("dot order wrong");

	property p_pad12;
		logic [9:0] d;
		(boundary && sel_next == 3'h7, d = parallel_dot_data_i)
			|=> !shift_reg[0] ##1 (shift_reg[0] == d[0]) ##9 (shift_reg[0] == d[9])
			##1 !shift_reg[0];
	endproperty
	a_pad12: assert property (p_pad12) else $error("twelve-dot padding wrong");

	property p_pad11;
		(boundary && sel_next == 3'h6) |=> !shift_reg[0];
	endproperty
	a_pad11: assert property (p_pad11) else $error("leading blank dot missing");

	property p_blank_bg;
		(blanking_i && !composite_blanking_i && background_select_i)
			|=> logic_video_high_o && logic_video_low_o && video_level_o == LEVEL_BLACK;
	endproperty
	a_blank_bg: assert property (p_blank_bg) else $error("blanking level wrong");

	property p_composite_blanking;
		composite_blanking_i |=> !logic_video_high_o && !logic_video_low_o;
	endproperty
	a_composite_blanking: assert property (p_composite_blanking) else $error("composite blanking not black");

	property p_char_mode;
		(boundary && !pipe2_reg.load_flag && !pipe2_reg.field_mode) |=> cur_reg == '0;
	endproperty
	a_char_mode: assert property (p_char_mode) else $error("attribute outlived character");

	property p_line_cap;
		$fell(blanking_i) |=> uline_line_reg == $past(underline_line_in_i);
	endproperty
	a_line_cap: assert property (p_line_cap) else $error("line input not captured");

	property p_nondisp;
		(!blanking_i && !composite_blanking_i && nondisp && !inv)
			|=> !logic_video_high_o && !logic_video_low_o;
	endproperty
	a_nondisp: assert property (p_nondisp) else $error("non-display not black");

	property p_rst_bound;
		$past(rst_i) |-> boundary;
	endproperty
	a_rst_bound: assert property (p_rst_bound) else $error("no boundary after reset");

	c_twelve: cover property (boundary && sel_reg == 3'h7);
	c_field:  cover property (boundary && pipe2_reg.load_flag && pipe2_reg.field_mode);
	c_half:   cover property (half_dot_o && !blanking_i);
	c_composite_blanking: cover property (composite_blanking_i && background_select_i);

endmodule : video_attribute_serializer

// file: shared/video_attribute_serializer_defines.svh
`ifndef VIDEO_ATTRIBUTE_SERIALIZER_DEFINES_SVH
`define VIDEO_ATTRIBUTE_SERIALIZER_DEFINES_SVH

// ***************************************************************
// register map
// ***************************************************************
`define CTRL_OFFSET       12'h000
`define STATUS_OFFSET     12'h004
`define CTRL_RESET        32'h0000_0000

// ***************************************************************
// control register fields
// ***************************************************************
`define CTRL_SEL_LSB      0
`define CTRL_SEL_MSB      2
`define CTRL_FIELD_BIT    3
`define CTRL_SHOWCTL_BIT  4
`define CTRL_WIDTH        5

// ***************************************************************
// status register fields
// ***************************************************************
`define STAT_CNT_LSB      0
`define STAT_CNT_MSB      3
`define STAT_CHARACTER_CLOCK_BIT     4
`define STAT_ATTR_LSB     5
`define STAT_ATTR_MSB     10

// ***************************************************************
// character timing
// ***************************************************************
`define DOTS_MIN          4'h6
`define DOTS_OFFSET       4'h5
`define SEL_PAD_FIRST     3'h6
`define SEL_PAD_BOTH      3'h7
`define DOT_CNT_RESET     4'h5

`endif

// file: shared/video_attribute_serializer_pkg.sv
package video_attribute_serializer_pkg;

	// latched attribute set
	typedef struct packed {
		logic reverse;
		logic highlight;
		logic blank;
		logic blink;
		logic uline;
		logic strike;
	} attr_t;

	// analog three-level output
	typedef enum logic [1:0] {
		LEVEL_BLACK = 2'b00,
		LEVEL_GRAY  = 2'b01,
		LEVEL_WHITE = 2'b10
	} level_t;

	// pipeline stage for per-character controls
	typedef struct packed {
		attr_t attr;
		logic  load_flag;
		logic  cursor;
		logic  half_dot;
		logic  field_mode;
		logic  show_ctl;
	} stage_t;

endpackage : video_attribute_serializer_pkg

// file: test/video_source_model.sv
`timescale 1ns/1ps

module video_source_model (
	input  wire logic       clk_i,
	input  wire logic       character_clock_i,
	input  wire logic [9:0] dots_i,
	input  wire logic [8:0] char_i,
	input  wire logic [3:0] line_i,
	input  wire logic [3:0] frame_i,
	output logic      [9:0] dots_o,
	output logic      [8:0] char_o,
	output logic      [3:0] line_o,
	output logic      [2:0] frame_o
);
	// ***************************************************************
	// timing controller and dot generator stand-in
	// ***************************************************************
	logic character_clock_prev_reg;

	// quiet levels before the first clock edge
	initial begin
		dots_o = 10'h000;
		char_o = 9'h000;
		line_o = 4'h0;
		frame_o = 3'h0;
	end

	// character clock history for edge detection
	always @(posedge clk_i) begin
		character_clock_prev_reg <= character_clock_i;
	end

	// per-character inputs move after the rise
	always @(posedge clk_i) begin
		if (character_clock_i && !character_clock_prev_reg) begin
			char_o <= char_i;
		end
	end

	// dot data moves after the fall, steady at the boundary
	always @(posedge clk_i) begin
		if (!character_clock_i && character_clock_prev_reg) begin
			dots_o <= dots_i;
		end
	end

	always @(posedge clk_i) begin
		if (frame_o[2]) begin
			line_o <= line_i;
		end
	end

	always @(posedge clk_i) begin
		frame_o <= {frame_i[3], frame_i[2], frame_i[1] | (frame_i[0] & frame_i[3])};
	end
endmodule : video_source_model

// file: test/video_attribute_serializer_test.sv
`timescale 1ns/1ps

module video_attribute_serializer_test
	import video_attribute_serializer_pkg::*;
;
	// ***************************************************************
	// stimulus and observation
	// ***************************************************************
	logic        clk_i = 1'h0;
	logic        rst_i = 1'h1;
	logic        psel = 1'h0;
	logic        penable = 1'h0;
	logic        pwrite = 1'h0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [9:0]  dots = 10'h2b5;
	logic [8:0]  chr = 9'h000;
	logic [3:0]  line = 4'h0;
	logic [3:0]  frame = 4'h0;
	logic [9:0]  dots_w;
	logic [8:0]  chr_w;
	logic [3:0]  line_w;
	logic [2:0]  frame_w;
	logic        character_clock;
	logic        vid_hi;
	logic        vid_lo;
	level_t      level;
	logic        half_dot_shift;
	logic [31:0] rd;
	logic        err;
	int          mismatches = 0;
	int          tests_run = 0;
	int          cycles = 0;
	// attribute cases: {bg,rev,cursor,hilt}{blank,blink,rate,half_dot_shift}{ul,ul line,strike,line}{sym,sur}
	logic [15:0] cases [15] = '{16'h0004, 16'h110c, 16'h0800, 16'h400b, 16'h200b, 16'h6004,
		16'h800b, 16'hc004, 16'h0600, 16'h0404, 16'h480f, 16'h00c5, 16'h003f, 16'h9003, 16'h0084};
	// blanking cases: {frame request, logic pair, analog level}
	logic [7:0]  blank_tbl [4] = '{8'h82, 8'hac, 8'h60, 8'h9c};

	// dot clock
	always #10 clk_i = ~clk_i;

	video_source_model partner (.clk_i(clk_i), .character_clock_i(character_clock), .dots_i(dots),
		.char_i(chr), .line_i(line), .frame_i(frame), .dots_o(dots_w), .char_o(chr_w),
		.line_o(line_w), .frame_o(frame_w));

	video_attribute_serializer dut (.clk_i(clk_i), .rst_i(rst_i), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .parallel_dot_data_i(dots_w),
		.reverse_attr_i(chr_w[8]), .highlight_attr_i(chr_w[7]), .blank_attr_i(chr_w[6]),
		.blink_attr_i(chr_w[5]), .underline_attr_i(chr_w[4]), .strike_attr_i(chr_w[3]),
		.attr_load_flag_i(chr_w[2]), .cursor_i(chr_w[1]), .half_dot_shift_i(chr_w[0]),
		.blanking_i(frame_w[2]), .composite_blanking_i(frame_w[1]),
		.background_select_i(frame_w[0]), .blink_rate_i(line_w[3]),
		.underline_line_in_i(line_w[2]), .strike_line_in_i(line_w[1]),
		.last_scan_line_in_i(line_w[0]), .character_clock_o(character_clock), .logic_video_high_o(vid_hi),
		.logic_video_low_o(vid_lo), .video_level_o(level), .half_dot_o(half_dot_shift));

	// ***************************************************************
	// tasks and test sequence
	// ***************************************************************
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : end_of_test

	// one bus transfer, held until pready is seen
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk_i);
		penable <= 1'h1;
		do @(posedge clk_i); while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge clk_i);
	endtask : apb

	// returns just after the edge that raises the character clock
	task automatic to_boundary();
		logic prev;
		prev = 1'h1;
		forever begin
			@(posedge clk_i);
			#1;
			if (character_clock === 1'h1 && prev === 1'h0) break;
			prev = character_clock;
		end
	endtask : to_boundary

	function automatic level_t lv(input logic [1:0] t);
		return (t == 2'h0) ? LEVEL_WHITE : (t == 2'h3) ? LEVEL_BLACK : LEVEL_GRAY;
	endfunction : lv

	// serial frame and character clock shape of one select code
	task automatic check_stream(input logic [2:0] code);
		int          nd;
		logic [11:0] f;
		nd = (code < 3'h2) ? 6 : code + 5;
		f = (code >= 3'h6) ? {1'h0, dots, 1'h0} : {2'h0, dots};
		apb(1'h1, 12'h000, {29'h0, code});
		to_boundary();
		to_boundary();
		// first dot reaches the outputs one edge after the boundary edge
		@(posedge clk_i);
		for (int k = 0; k < nd; k++) begin
			#1;
			chk("dot", {1'h0, f[k]}, {vid_hi, vid_lo});
			chk("char clock", ((k + 1) % nd) < (nd + 1) / 2, character_clock);
			@(posedge clk_i);
		end
	endtask : check_stream

	// surround dot 1 and symbol dot 5 once the attribute pipeline is full
	task automatic attr_case(input logic [15:0] c, input logic drop);
		chr <= {c[14], c[12:10], c[7], c[5], 1'h1, c[13], c[8]};
		line <= {c[9], c[6], c[4], 1'h0};
		frame <= {2'h2, c[15], 1'h0};
		repeat (4) @(posedge clk_i);
		frame[3] <= 1'h0;
		repeat (5) to_boundary();
		if (drop) begin
			@(posedge clk_i);
			chr <= 9'h000;
			repeat (4) to_boundary();
		end
		repeat (2) @(posedge clk_i);
		#1;
		chk("surround", c[1:0], {vid_hi, vid_lo});
		chk("analog", lv(c[1:0]), level);
		chk("half dot", c[8], half_dot_shift);
		repeat (4) @(posedge clk_i);
		#1;
		chk("symbol", c[3:2], {vid_hi, vid_lo});
		@(posedge clk_i);
	endtask : attr_case

	// hang guard
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			end_of_test();
		end
	end

	initial begin
		repeat (15) @(posedge clk_i);
		#1;
		chk("reset outputs", 4'h0, {vid_hi, vid_lo, character_clock, half_dot_shift});
		chk("reset analog", LEVEL_BLACK, level);
		@(posedge clk_i);
		rst_i <= 1'h0;
		@(posedge clk_i);
		#1;
		chk("first boundary", 1'h1, character_clock);
		@(posedge clk_i);
		apb(1'h0, 12'h000, 32'h0);
		chk("ctrl reset", 32'h0, rd);
		apb(1'h1, 12'h000, 32'hffff_ffff);
		apb(1'h0, 12'h000, 32'h0);
		chk("ctrl write", 32'h1f, rd);
		apb(1'h0, 12'h008, 32'h0);
		chk("unmapped error", 32'h1, err);
		chk("unmapped data", 32'h0, rd);
		$display("register test done");
		for (int i = 0; i < 8; i++) check_stream(i[2:0]);
		$display("stream test done");
		dots <= 10'h0f0;
		foreach (blank_tbl[i]) begin
			frame <= blank_tbl[i][7:4];
			repeat (4) @(posedge clk_i);
			#1;
			chk("blank video", blank_tbl[i][3:2], {vid_hi, vid_lo});
			chk("blank analog", blank_tbl[i][1:0], level);
			@(posedge clk_i);
		end
		frame <= 4'h0;
		$display("blanking test done");
		apb(1'h1, 12'h000, 32'h5);
		foreach (cases[i]) attr_case(cases[i], 1'h0);
		attr_case(16'h1004, 1'h1);
		apb(1'h1, 12'h000, 32'h1d);
		attr_case(16'h100c, 1'h1);
		apb(1'h1, 12'h000, 32'hd);
		attr_case(16'h1000, 1'h0);
		$display("attribute test done");
		end_of_test();
	end
endmodule : video_attribute_serializer_test
